// file: logic/wdt_defs.svh
// Watchdog register map, codes, field positions and timing constants
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_ADDR_CONFIG   8'h34
`define WDT_ADDR_COMMAND  8'h35
`define WDT_ADDR_STATUS   8'h36
`define WDT_CLEAR_CODE    8'h4e
`define WDT_DISABLE_CODE  8'hb1
`define WDT_CFG_RESET     4'h9
`define WDT_EN_BIT        3
`define WDT_DT_HI         2
`define WDT_DT_LO         1
`define WDT_ACT_BIT       0
`define WDT_BIN_MAX       2'h3
`define WDT_BIN_BITS      2
`define WDT_RST_TIME_NS   1200
`define WDT_CLK_PERIOD_NS 50
`define WDT_RST_CYCLES    (`WDT_RST_TIME_NS / `WDT_CLK_PERIOD_NS)
`define WDT_RDATA_NONE    8'h00
`endif

// file: logic/wdt_pkg.sv
// Watchdog types
package wdt_pkg;
   typedef enum logic {
      WDT_ACT_IRQ = 1'b0,
      WDT_ACT_RST = 1'b1
   } wdt_action_t;
   typedef enum logic [1:0] {
      WDT_DT_2E25 = 2'h0,
      WDT_DT_2E23 = 2'h1,
      WDT_DT_2E21 = 2'h2,
      WDT_DT_2E19 = 2'h3
   } wdt_dtime_t;
endpackage

// file: logic/wdt_watchdog.sv
// Watchdog timer: divider, two-stage binary counter, overflow action, register port
// How it works
// R1: Watchdog runs from reset release with no software start.
// R2: Overflow asks reset when action bit is 1, interrupt when 0.
// R3: Divider and counter freeze in stop and idle, resume from held count.
// R4: Clear code zeroes only the binary counter, divider keeps running.
// R5: Software clears within three quarters of detection time.
// R6: Detection code picks 2^25/23/21/19 clocks, doubled by prescale-double.
// R7: After action bit written 0, writing 1 is ignored until reset.
// R8: Config register is write-only; reads return no data.
// R9: Command register is write-only; reads return no data.
// R10: Disable code works only while the enable bit already holds 0.
// R11: Software disables by master flag off, clear, enable 0, disable code.
// R12: Binary counter held at zero while disabled.
// R13: Pending interrupt stays set when watchdog is disabled meanwhile.
// R14: Watchdog interrupt ignores the interrupt master flag.
// R15: New watchdog interrupt raised even while another is in service.
// R16: Software sets the stack pointer before choosing interrupt action.
// R17: Reset request lasts no more than 24 clock periods.
// R18: Software disables or clears before stop, clears again after.
// R19: Software never clears the counter inside an interrupt routine.
// R20: Reset loads config low nibble with 1001.
// R21: Action choice programmable once after reset; reset restores reset action.
// R22: Config: enable bit 3, detection time bits 2..1, action bit 0.
// R23: Other command values have no effect.
`include "wdt_defs.svh"

module wdt_watchdog
   import wdt_pkg::*;
#(
   parameter int DET_EXP_BASE = 25
) (
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_prescale_double_sel,
   input  wire logic       i_stop_mode,
   input  wire logic       i_idle_mode,
   input  wire logic       i_irq_ack,
   output logic      [7:0] o_rdata,
   output logic            o_watchdog_irq,
   output logic            o_wdt_reset_req
);

   localparam int DIV_W   = DET_EXP_BASE - 1;
   localparam int RST_CYC = `WDT_RST_CYCLES;
   localparam int RST_W   = $clog2(RST_CYC + 1);

   logic [DIV_W-1:0]         div_reg;
   logic [`WDT_BIN_BITS-1:0] bin_reg;
   logic                     en_bit_reg;
   wdt_dtime_t               dtime_reg;
   wdt_action_t              action_reg;
   logic                     running_reg;
   logic [RST_W-1:0]         rst_cnt_reg;
   logic [RST_W-1:0]         req_len_reg;
   logic [DIV_W-1:0]         tick_mask;
   logic                     frozen;
   logic                     tick;
   logic                     ovf;
   logic                     cfg_wr;
   logic                     cmd_wr;
   logic                     clr_cmd;
   logic                     dis_cmd;

   // Register port decode
   always_comb begin
      cfg_wr = 1'b0;
      cmd_wr = 1'b0;
      if (i_wr && i_addr == `WDT_ADDR_CONFIG) begin
         cfg_wr = 1'b1;
      end else if (i_wr && i_addr == `WDT_ADDR_COMMAND) begin
         cmd_wr = 1'b1;
      end
   end

   // R23: only two codes act
   assign clr_cmd = cmd_wr && i_wdata == `WDT_CLEAR_CODE;
   assign dis_cmd = cmd_wr && i_wdata == `WDT_DISABLE_CODE;

   // R3: stop and idle freeze
   assign frozen = i_stop_mode || i_idle_mode;

   // R6: divider tap from detection code
   always_comb begin
      int k;
      k = DET_EXP_BASE - 2 - 2 * int'(dtime_reg) + int'(i_prescale_double_sel);
      tick_mask = DIV_W'((64'h1 << k) - 64'h1);
   end

   assign tick = !frozen && ((div_reg | ~tick_mask) == {DIV_W{1'b1}});
   assign ovf  = tick && running_reg && bin_reg == `WDT_BIN_MAX;

   // R3: divider free-running unless frozen
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_reg <= '0;
      end else if (!frozen) begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end

   // R4: clear code zeroes counter only
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bin_reg <= '0;
      end else if (!running_reg || clr_cmd || (dis_cmd && !en_bit_reg)) begin
         // R12: held at zero when disabled
         bin_reg <= '0;
      end else if (tick) begin
         bin_reg <= bin_reg + `WDT_BIN_BITS'(1);
      end
   end

   // R20: config reset value 1001
   // R21: reset restores the reset action
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         en_bit_reg <= 1'(`WDT_CFG_RESET >> `WDT_EN_BIT);
         dtime_reg  <= wdt_dtime_t'(2'(`WDT_CFG_RESET >> `WDT_DT_LO));
         action_reg <= wdt_action_t'(1'(`WDT_CFG_RESET >> `WDT_ACT_BIT));
      end else if (cfg_wr) begin
         // R22: field placement
         en_bit_reg <= i_wdata[`WDT_EN_BIT];
         dtime_reg  <= wdt_dtime_t'(i_wdata[`WDT_DT_HI:`WDT_DT_LO]);
         // R7: action bit only ever goes to 0
         action_reg <= wdt_action_t'(i_wdata[`WDT_ACT_BIT] & action_reg);
      end
   end

   // R1: armed at reset release
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         running_reg <= 1'b1;
      end else if (cfg_wr && i_wdata[`WDT_EN_BIT]) begin
         running_reg <= 1'b1;
      end else if (dis_cmd && !en_bit_reg) begin
         // R10: disable needs enable bit 0
         running_reg <= 1'b0;
      end
   end

   // R2: interrupt path; R14: no master-flag gate; R13: ack only clears
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_watchdog_irq <= 1'b0;
      end else if (ovf && action_reg == WDT_ACT_IRQ) begin
         // R15: raised even when one is in service
         o_watchdog_irq <= 1'b1;
      end else if (i_irq_ack) begin
         o_watchdog_irq <= 1'b0;
      end
   end

   // R17: reset request for 24 cycles
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rst_cnt_reg     <= '0;
         o_wdt_reset_req <= 1'b0;
      end else if (ovf && action_reg == WDT_ACT_RST) begin
         rst_cnt_reg     <= RST_W'(RST_CYC);
         o_wdt_reset_req <= 1'b1;
      end else if (rst_cnt_reg > RST_W'(1)) begin
         rst_cnt_reg     <= rst_cnt_reg - RST_W'(1);
         o_wdt_reset_req <= 1'b1;
      end else begin
         rst_cnt_reg     <= '0;
         o_wdt_reset_req <= 1'b0;
      end
   end

   // R17: length of the running reset request
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         req_len_reg <= '0;
      end else if (o_wdt_reset_req) begin
         req_len_reg <= req_len_reg + RST_W'(1);
      end else begin
         req_len_reg <= '0;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= `WDT_RDATA_NONE;
      end else if (i_rd && i_addr == `WDT_ADDR_STATUS) begin
         o_rdata <= {2'h0, o_wdt_reset_req, o_watchdog_irq,
                     running_reg, action_reg, bin_reg};
      end else begin
         // R8: config reads give nothing; R9: command reads likewise
         o_rdata <= `WDT_RDATA_NONE;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   AST_STOP_ONLY_BY_CODE: assert property ( // R1
      $fell(running_reg) |-> $past(dis_cmd) && !$past(en_bit_reg))
      else $error("watchdog stopped without a valid disable");

   AST_OVF_RESET: assert property ( // R2
      ovf && action_reg == WDT_ACT_RST |=> o_wdt_reset_req && !$rose(o_watchdog_irq))
      else $error("overflow with reset action gave no reset request");

   AST_OVF_IRQ: assert property ( // R14
      ovf && action_reg == WDT_ACT_IRQ |=> o_watchdog_irq && !o_wdt_reset_req)
      else $error("overflow with interrupt action gave no interrupt");

   AST_FREEZE: assert property ( // R3
      frozen && running_reg && !clr_cmd |=> $stable(bin_reg) && $stable(div_reg))
      else $error("count moved while frozen");

   AST_CLEAR_KEEPS_DIV: assert property ( // R4
      clr_cmd && !frozen |=> bin_reg == '0 && div_reg == $past(div_reg) + DIV_W'(1))
      else $error("clear code disturbed divider or left counter");

   AST_ACTION_STICKY: assert property ( // R7
      action_reg == WDT_ACT_IRQ |=> action_reg == WDT_ACT_IRQ)
      else $error("action bit returned to reset");

   AST_DISABLED_ZERO: assert property ( // R12
      !running_reg |-> bin_reg == '0 && !ovf)
      else $error("counter not zero while disabled");

   AST_IRQ_HELD: assert property ( // R13
      o_watchdog_irq && !i_irq_ack |=> o_watchdog_irq)
      else $error("interrupt request dropped without acknowledge");

   AST_RST_BOUND: assert property ( // R17
      $rose(o_wdt_reset_req) |-> o_wdt_reset_req[*8] ##1 o_wdt_reset_req[*8]
                                 ##1 o_wdt_reset_req[*8] ##1 !o_wdt_reset_req)
      else $error("reset request length wrong");

   AST_WO_READ: assert property ( // R9
      i_rd && i_addr != `WDT_ADDR_STATUS |=> o_rdata == `WDT_RDATA_NONE)
      else $error("write-only register returned data");

   AST_OTHER_CMD: assert property ( // R23
      cmd_wr && !clr_cmd && !dis_cmd && !cfg_wr |=> $stable(running_reg))
      else $error("unknown command changed state");

   AST_CFG_FIELDS: assert property ( // R22
      cfg_wr |=> dtime_reg == $past(i_wdata[`WDT_DT_HI:`WDT_DT_LO])
                 && en_bit_reg == $past(i_wdata[`WDT_EN_BIT]))
      else $error("config fields misplaced");

   AST_RST_ONLY_ON_OVF: assert property ( // R2
      $rose(o_wdt_reset_req) |-> $past(ovf && action_reg == WDT_ACT_RST))
      else $error("reset request without overflow");

   AST_IRQ_ONLY_ON_OVF: assert property ( // R2
      $rose(o_watchdog_irq) |-> $past(ovf && action_reg == WDT_ACT_IRQ))
      else $error("interrupt without overflow");

   AST_RST_ACTION_NO_IRQ: assert property ( // R2
      action_reg == WDT_ACT_RST && !o_watchdog_irq |=> !o_watchdog_irq)
      else $error("interrupt raised under reset action");

   AST_IRQ_ACTION_NO_REQ: assert property ( // R2
      action_reg == WDT_ACT_IRQ && !o_wdt_reset_req |=> !o_wdt_reset_req)
      else $error("reset request raised under interrupt action");

   AST_DISABLE_NEEDS_EN0: assert property ( // R10
      dis_cmd && en_bit_reg |=> running_reg == $past(running_reg))
      else $error("disable code acted while enable bit set");

   AST_DISABLE_TAKES: assert property ( // R10
      dis_cmd && !en_bit_reg |=> !running_reg)
      else $error("valid disable ignored");

   AST_EN0_ALONE_RUNS: assert property ( // R10
      cfg_wr && !i_wdata[`WDT_EN_BIT] && running_reg |=> running_reg)
      else $error("enable bit write alone stopped the watchdog");

   AST_ENABLE_WRITE: assert property ( // R1
      cfg_wr && i_wdata[`WDT_EN_BIT] |=> running_reg)
      else $error("enable write did not start the watchdog");

   AST_RUN_AFTER_RESET: assert property ( // R1
      $fell(i_sys_rst) |-> running_reg && bin_reg == '0)
      else $error("watchdog not armed after reset");

   AST_CFG_RESET: assert property ( // R20
      $fell(i_sys_rst) |-> en_bit_reg && dtime_reg == WDT_DT_2E25
                           && action_reg == WDT_ACT_RST)
      else $error("config reset value wrong");

   AST_ACTION_WRITE_ZERO: assert property ( // R21
      cfg_wr && !i_wdata[`WDT_ACT_BIT] |=> action_reg == WDT_ACT_IRQ)
      else $error("action bit write of 0 lost");

   AST_IRQ_WINS_ACK: assert property ( // R15
      ovf && action_reg == WDT_ACT_IRQ && i_irq_ack |=> o_watchdog_irq)
      else $error("new interrupt lost to acknowledge");

   AST_DISABLE_KEEPS_IRQ: assert property ( // R13
      o_watchdog_irq && dis_cmd && !i_irq_ack |=> o_watchdog_irq)
      else $error("disable cleared pending interrupt");

   AST_ACK_CLEARS: assert property ( // R13
      i_irq_ack && !ovf |=> !o_watchdog_irq)
      else $error("acknowledge did not clear interrupt");

   AST_DIV_RUNS: assert property ( // R4
      !frozen |=> div_reg == $past(div_reg) + DIV_W'(1))
      else $error("divider did not advance");

   AST_CLEAR_ZERO: assert property ( // R4
      clr_cmd |=> bin_reg == '0)
      else $error("clear code left counter");

   AST_RUN_RESUMES: assert property ( // R3
      $fell(frozen) && running_reg && !$past(clr_cmd) |-> $stable(bin_reg))
      else $error("count not held across freeze");

   AST_OTHER_CMD_BIN: assert property ( // R23
      cmd_wr && !clr_cmd && !dis_cmd && running_reg && !tick |=> $stable(bin_reg))
      else $error("unknown command moved counter");

   AST_RDATA_ONE_CYCLE: assert property ( // R8
      !i_rd |=> o_rdata == `WDT_RDATA_NONE)
      else $error("read data without strobe");

   AST_RST_MAX: assert property ( // R17
      o_wdt_reset_req |-> req_len_reg < RST_W'(RST_CYC))
      else $error("reset request too long");

   CV_IRQ:     cover property (ovf && action_reg == WDT_ACT_IRQ);
   CV_RESET:   cover property ($fell(o_wdt_reset_req));
   CV_DISABLE: cover property ($fell(running_reg));
   CV_CLEAR:   cover property (clr_cmd && bin_reg != '0);
   CV_FREEZE:  cover property (frozen && bin_reg != '0);

endmodule

// file: bench/watchdog_timer_control_test.sv
// Self-checking bench for the watchdog block
module watchdog_timer_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   logic       i_clk = 1'b0;
   logic       i_sys_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic       i_wr = 1'b0;
   logic       i_rd = 1'b0;
   logic       i_prescale_double_sel = 1'b0;
   logic       i_stop_mode = 1'b0;
   logic       i_idle_mode = 1'b0;
   logic       i_irq_ack = 1'b0;
   logic [7:0] o_rdata;
   logic       o_watchdog_irq;
   logic       o_wdt_reset_req;
   logic       rd_seen = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] mask_q[$];
   logic [31:0] rnd = 32'h2cf7b976;
   int n_errors = 0;
   int check_count = 0;
   int n;

   always #25 i_clk = ~i_clk;

   wdt_watchdog #(.DET_EXP_BASE(9)) u_wdt_watchdog (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_prescale_double_sel(i_prescale_double_sel),
      .i_stop_mode(i_stop_mode), .i_idle_mode(i_idle_mode), .i_irq_ack(i_irq_ack),
      .o_rdata(o_rdata), .o_watchdog_irq(o_watchdog_irq), .o_wdt_reset_req(o_wdt_reset_req));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic check_rd(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      check_count++;
      if ((got & m) !== exp) begin
         n_errors++;
         $display("ERROR at %0t: read %0h expected %0h", $time, got & m, exp);
      end
   endtask

   // Watcher: read data stand in the cycle after the strobe
   always @(posedge i_clk) rd_seen <= i_rd;
   always @(negedge i_clk) begin
      if (rd_seen) check_rd(o_rdata, exp_q.pop_front(), mask_q.pop_front());
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      mask_q.push_back(m);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask

   task automatic ack();
      @(posedge i_clk);
      i_irq_ack <= 1'b1;
      @(posedge i_clk);
      i_irq_ack <= 1'b0;
   endtask

   task automatic wait_irq(input int lim);
      n = 0;
      @(negedge i_clk);
      while (o_watchdog_irq !== 1'b1 && n < lim) begin
         @(negedge i_clk);
         n++;
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      give_verdict();
   end

   initial begin
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(8'h36, 8'h0c, 8'hff);
      rd(8'h34, 8'h00, 8'hff);
      rd(8'h35, 8'h00, 8'hff);
      rd(8'hc3, 8'h00, 8'hff);
      $display("test 1 done");
      for (int i = 0; i < 4; i++) begin
         rnd = xorshift(rnd);
         if (rnd[7:0] != 8'h4e && rnd[7:0] != 8'hb1) wr(8'h35, rnd[7:0]);
      end
      wr(8'h35, 8'hb1);
      rd(8'h36, 8'h0c, 8'h3c);
      $display("test 2 done");
      wr(8'h34, 8'hf9);
      wr(8'h35, 8'h4e);
      n = 0;
      while (o_wdt_reset_req !== 1'b1 && n < 600) begin
         @(negedge i_clk);
         n++;
      end
      n = 0;
      while (o_wdt_reset_req === 1'b1 && n < 40) begin
         @(negedge i_clk);
         n++;
      end
      chk(n, 24);
      chk(o_watchdog_irq, 1'b0);
      $display("test 3 done");
      wr(8'h34, 8'h0e);
      wr(8'h34, 8'h0f);
      rd(8'h36, 8'h00, 8'h04);
      for (int c = 0; c < 4; c++) begin
         for (int d = 0; d < 2; d++) begin
            @(posedge i_clk);
            i_prescale_double_sel <= d[0];
            wr(8'h34, {4'h0, 1'b1, c[1:0], 1'b1});
            wr(8'h35, 8'h4e);
            ack();
            wait_irq(3000);
            chk(n >= (3 << (7 - 2 * c + d)) - 2 && n <= (4 << (7 - 2 * c + d)), 1);
            chk(o_wdt_reset_req, 1'b0);
            ack();
         end
      end
      $display("test 4 done");
      i_prescale_double_sel <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         wr(8'h35, 8'h4e);
         @(posedge i_clk);
         if (m == 0) i_idle_mode <= 1'b1;
         else i_stop_mode <= 1'b1;
         wr(8'h35, 8'h4e);
         ack();
         rd(8'h36, 8'h00, 8'h13);
         repeat (200) @(posedge i_clk);
         rd(8'h36, 8'h00, 8'h13);
         i_idle_mode <= 1'b0;
         i_stop_mode <= 1'b0;
         wait_irq(14);
         chk(o_watchdog_irq, 1'b1);
         if (m == 0) ack();
      end
      $display("test 5 done");
      wr(8'h35, 8'h4e);
      wr(8'h34, 8'h06);
      wr(8'h35, 8'hb1);
      rd(8'h36, 8'h10, 8'h1b);
      repeat (300) @(posedge i_clk);
      rd(8'h36, 8'h10, 8'h3b);
      ack();
      rd(8'h36, 8'h00, 8'h10);
      $display("test 6 done");
      repeat (4) @(posedge i_clk);
      give_verdict();
   end
endmodule
